// >>> hw/spf_pkg.sv
// spf_pkg: register map, field layout and reset values of the fifo level block
// assumes a 32-bit avalon-mm slave with word addresses
package spf_pkg;
  localparam int unsigned SPF_DEPTH = 8;
  localparam int unsigned SPF_DW = 16;
  localparam int unsigned SPF_AW = 2;
  // word offsets
  localparam logic [1:0] SPF_OFF_LVL = 2'h0;
  localparam logic [1:0] SPF_OFF_CTRL = 2'h1;
  localparam logic [1:0] SPF_OFF_TXDATA = 2'h2;
  localparam logic [1:0] SPF_OFF_RXDATA = 2'h3;
  // level/threshold register fields
  localparam int unsigned SPF_RX_WM_LSB = 0;
  localparam int unsigned SPF_RX_CNT_LSB = 4;
  localparam int unsigned SPF_TX_WM_LSB = 8;
  localparam int unsigned SPF_TX_CNT_LSB = 12;
  // control register fields, then threshold reset values, full count and unmapped read value
  localparam int unsigned SPF_EN_BIT = 0;
  localparam int unsigned SPF_TXQ_EN_BIT = 1;
  localparam logic [3:0] SPF_RX_WM_RST = 4'h8;
  localparam logic [3:0] SPF_TX_WM_RST = 4'h1;
  localparam logic [3:0] SPF_FULL = 4'h8;
  localparam logic [31:0] SPF_UNMAPPED = 32'h0000_0000;
endpackage : spf_pkg

// >>> hw/spf_queue.sv
// spf_queue: eight-word queue with fill count and synchronous flush
// assumes caller never pushes when full or pops when empty
module spf_queue
  import spf_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [SPF_DW-1:0] push_data_i,
  input wire logic pop_i,
  output logic [SPF_DW-1:0] head_o,
  output logic [3:0] count_o
);
  logic [SPF_DW-1:0] mem [SPF_DEPTH];
  logic [2:0] wr_q;
  logic [2:0] rd_q;
  logic [3:0] cnt_q;

  assign head_o = mem[rd_q];
  assign count_o = cnt_q;

  always_ff @(posedge core_clk_i)
  begin
    if (push_i)
    begin
      mem[wr_q] <= push_data_i;
    end
  end

  // flush wins over a same-cycle push or pop
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_q <= 3'h0;
      rd_q <= 3'h0;
      cnt_q <= 4'h0;
    end
    else if (flush_i)
    begin
      wr_q <= 3'h0;
      rd_q <= 3'h0;
      cnt_q <= 4'h0;
    end
    else
    begin
      if (push_i)
      begin
        wr_q <= wr_q + 3'h1;
      end
      if (pop_i)
      begin
        rd_q <= rd_q + 3'h1;
      end
      if (push_i && !pop_i)
      begin
        cnt_q <= cnt_q + 4'h1;
      end
      else if (pop_i && !push_i)
      begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : spf_queue

// >>> hw/spf_fifo_flags.sv
// spf_fifo_flags: tx/rx queues, fill counts, watermark flags, avalon-mm slave
// assumes shifters sit on core_clk_i and respect the ready signals
module spf_fifo_flags
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [spf_pkg::SPF_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic tx_shift_load_i,
  output logic tx_shift_valid_o,
  output logic [spf_pkg::SPF_DW-1:0] tx_shift_data_o,
  input wire logic rx_shift_valid_i,
  input wire logic [spf_pkg::SPF_DW-1:0] rx_shift_data_i,
  output logic rx_shift_ready_o,
  output logic port_enable_o,
  output logic rx_full_flag_o,
  output logic tx_empty_flag_o
);
  import spf_pkg::*;

  logic port_enable_q;
  logic tx_queue_enable_q;
  logic [3:0] rx_full_threshold_q;
  logic [3:0] tx_empty_threshold_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [SPF_DW-1:0] tx_data_register_q;
  logic tx_hold_q;
  logic [3:0] tx_fill_count;
  logic [3:0] rx_fill_count;
  logic [SPF_DW-1:0] txq_head;
  logic [SPF_DW-1:0] rxq_head;
  logic txq_push;
  logic txq_pop;
  logic rxq_push;
  logic rxq_pop;
  logic flush;
  logic wr_ok;
  logic rd_ok;
  logic tx_room;
  logic [15:0] lvl_word;
  logic wait_q;

  // one wait cycle per access, then ack; request taken at the ack edge
  // waitrequest kept in its own flop so the pin has no gate after it
  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;
  assign wr_ok = avs_write_i && ack_q;
  assign rd_ok = avs_read_i && ack_q;
  assign flush = !port_enable_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
    end
    else
    begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
      wait_q <= !((avs_read_i || avs_write_i) && !ack_q);
    end
  end

  // queue disabled: one queue slot behind the data register
  assign tx_room = tx_queue_enable_q ? (tx_fill_count < SPF_FULL)
                                     : (tx_fill_count == 4'h0);
  assign txq_push = wr_ok && avs_address_i == SPF_OFF_TXDATA
                    && port_enable_q && tx_room && avs_byteenable_i[0];
  // tx_data_register_q is the word in the shifter's hands
  assign txq_pop = port_enable_q && tx_fill_count != 4'h0
                   && (!tx_hold_q || tx_shift_load_i);
  assign rxq_push = port_enable_q && rx_shift_valid_i
                    && rx_fill_count < SPF_FULL;
  assign rxq_pop = rd_ok && avs_address_i == SPF_OFF_RXDATA
                   && rx_fill_count != 4'h0;

  spf_queue u_txq
  (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(flush),
    .push_i(txq_push),
    .push_data_i(avs_writedata_i[SPF_DW-1:0]),
    .pop_i(txq_pop),
    .head_o(txq_head),
    .count_o(tx_fill_count)
  );

  spf_queue u_rxq
  (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(flush),
    .push_i(rxq_push),
    .push_data_i(rx_shift_data_i),
    .pop_i(rxq_pop),
    .head_o(rxq_head),
    .count_o(rx_fill_count)
  );

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_hold_q <= 1'b0;
      tx_data_register_q <= 16'h0000;
    end
    else if (flush)
    begin
      tx_hold_q <= 1'b0;
      tx_data_register_q <= 16'h0000;
    end
    else if (txq_pop)
    begin
      tx_hold_q <= 1'b1;
      tx_data_register_q <= txq_head;
    end
    else if (tx_shift_load_i)
    begin
      tx_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      port_enable_q <= 1'b0;
      tx_queue_enable_q <= 1'b0;
    end
    else if (wr_ok && avs_address_i == SPF_OFF_CTRL && avs_byteenable_i[0])
    begin
      port_enable_q <= avs_writedata_i[SPF_EN_BIT];
      tx_queue_enable_q <= avs_writedata_i[SPF_TXQ_EN_BIT];
    end
  end

  // zero thresholds are not trapped; software keeps them 1..8
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_full_threshold_q <= SPF_RX_WM_RST;
      tx_empty_threshold_q <= SPF_TX_WM_RST;
    end
    else if (wr_ok && avs_address_i == SPF_OFF_LVL)
    begin
      if (avs_byteenable_i[0])
      begin
        rx_full_threshold_q <= avs_writedata_i[SPF_RX_WM_LSB +: 4];
      end
      if (avs_byteenable_i[1])
      begin
        tx_empty_threshold_q <= avs_writedata_i[SPF_TX_WM_LSB +: 4];
      end
    end
  end

  assign lvl_word = {tx_fill_count, tx_empty_threshold_q,
                     rx_fill_count, rx_full_threshold_q};

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (avs_read_i && !ack_q)
    begin
      case (avs_address_i)
        SPF_OFF_LVL: rdata_q <= {16'h0000, lvl_word};
        SPF_OFF_CTRL: rdata_q <= {30'h0000_0000, tx_queue_enable_q,
                                  port_enable_q};
        SPF_OFF_RXDATA: rdata_q <= {16'h0000, rxq_head};
        default: rdata_q <= SPF_UNMAPPED;
      endcase
    end
  end

  // flags registered from current levels: one cycle behind the count
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_full_flag_o <= 1'b0;
      tx_empty_flag_o <= 1'b0;
      tx_shift_valid_o <= 1'b0;
      tx_shift_data_o <= 16'h0000;
      rx_shift_ready_o <= 1'b0;
      port_enable_o <= 1'b0;
    end
    else
    begin
      rx_full_flag_o <= rx_fill_count >= rx_full_threshold_q;
      tx_empty_flag_o <= {1'b0, tx_fill_count} + {1'b0, tx_empty_threshold_q}
                         <= {1'b0, SPF_FULL};
      tx_shift_valid_o <= port_enable_q && (txq_pop || (tx_hold_q
                          && !tx_shift_load_i));
      tx_shift_data_o <= txq_pop ? txq_head : tx_data_register_q;
      rx_shift_ready_o <= port_enable_q && rx_fill_count < SPF_FULL
                          && !(rxq_push && rx_fill_count == 4'h7);
      port_enable_o <= port_enable_q;
    end
  end
endmodule : spf_fifo_flags

// >>> sim/spf_fifo_flags_asserts.sv
// spf_fifo_flags_asserts: port checks of the fifo level block
// assumes one clock domain; bound to every spf_fifo_flags
module spf_fifo_flags_asserts
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic tx_shift_load_i,
  input wire logic tx_shift_valid_o,
  input wire logic port_enable_o,
  input wire logic rx_full_flag_o,
  input wire logic tx_empty_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_req; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
  sequence s_ack; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
  sequence s_off; !port_enable_o ##1 !port_enable_o; endsequence
  property p_ack; s_req |=> s_ack; endproperty
  property p_idle; !(avs_read_i || avs_write_i) |-> avs_waitrequest_o;
  endproperty
  property p_hold; !avs_read_i |=> $stable(avs_readdata_o); endproperty
  property p_rst; $rose(rst_n_i) |=> tx_empty_flag_o && !rx_full_flag_o;
  endproperty
  // flush takes an edge, flags one more
  property p_off; s_off |=> tx_empty_flag_o && !rx_full_flag_o; endproperty
  property p_offv; s_off |-> !tx_shift_valid_o; endproperty
  property p_txv; tx_shift_valid_o && !tx_shift_load_i |=>
    tx_shift_valid_o || !port_enable_o; endproperty
  property p_pen; $changed(port_enable_o) |->
    $past(avs_write_i && !avs_waitrequest_o, 2); endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle late");
  a_idle: assert property (p_idle) else $error("ack without request");
  a_hold: assert property (p_hold) else $error("readdata moved");
  a_rst: assert property (p_rst) else $error("flags after reset");
  a_off: assert property (p_off) else $error("flags when off");
  a_offv: assert property (p_offv) else $error("tx word when off");
  a_txv: assert property (p_txv) else $error("tx word lost");
  a_pen: assert property (p_pen) else $error("enable moved");
endmodule : spf_fifo_flags_asserts

bind spf_fifo_flags spf_fifo_flags_asserts u_chk (.core_clk_i, .rst_n_i,
  .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
  .tx_shift_load_i, .tx_shift_valid_o, .port_enable_o, .rx_full_flag_o,
  .tx_empty_flag_o);

// >>> sim/spf_shift_model.sv
// spf_shift_model: tx and rx shifters, one word per bench command
// assumes commands arrive on core_clk_i, one cycle each
module spf_shift_model
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic tx_pop_i,
  input wire logic tx_valid_i,
  input wire logic [spf_pkg::SPF_DW-1:0] tx_data_i,
  output logic tx_load_o,
  output logic [spf_pkg::SPF_DW-1:0] tx_word_o,
  input wire logic rx_push_i,
  input wire logic [spf_pkg::SPF_DW-1:0] rx_word_i,
  input wire logic rx_ready_i,
  output logic rx_valid_o,
  output logic [spf_pkg::SPF_DW-1:0] rx_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge core_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      tx_load_o <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o <= '0;
    end
    else
    begin
      tx_load_o <= tx_pop_i && tx_valid_i;
      rx_valid_o <= rx_push_i && rx_ready_i;
      // idle data churns so a stale word never looks valid
      rx_data_o <= (rx_push_i && rx_ready_i) ? rx_word_i : ~rx_data_o;
    end
  always_ff @(posedge core_clk_i)
    if (tx_load_o)
      tx_word_o <= tx_data_i;
endmodule : spf_shift_model

// >>> sim/spf_fifo_flags_bench.sv
// spf_fifo_flags_bench: register tests of the fifo level block
// assumes spf_shift_model on the shifter ports
module spf_fifo_flags_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import spf_pkg::*;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, pop = 0, push = 0;
  logic [1:0] adr = 2'h0;
  logic [31:0] wd = 32'h0, rdata, q;
  logic [15:0] rxw = 16'h0, txw, txd, rxd;
  logic load, txv, rxv, rxr, wt, rx_full_flag, tx_empty_flag, pen;
  int fails = 0, compares = 0;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("FAIL %0t %h %h", $time, a, b); end end
  always #10 clk = ~clk;
  spf_fifo_flags DUT (.core_clk_i(clk), .rst_n_i(rst_n),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wt), .tx_shift_load_i(load), .tx_shift_valid_o(txv),
    .tx_shift_data_o(txd), .rx_shift_valid_i(rxv), .rx_shift_data_i(rxd),
    .rx_shift_ready_o(rxr), .port_enable_o(pen), .rx_full_flag_o(rx_full_flag),
    .tx_empty_flag_o(tx_empty_flag));
  spf_shift_model u_sh (.core_clk_i(clk), .rst_n_i(rst_n), .tx_pop_i(pop),
    .tx_valid_i(txv), .tx_data_i(txd), .tx_load_o(load), .tx_word_o(txw),
    .rx_push_i(push), .rx_word_i(rxw), .rx_ready_i(rxr),
    .rx_valid_o(rxv), .rx_data_o(rxd));
  task automatic bus(input logic w, input logic [1:0] a,
    input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    do @(posedge clk); while (wt !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  // sweep one side's threshold over 1..8 at the present fill level
  task automatic sweep(input bit tx, input int n);
    for (int i = 1; i <= 8; i++)
    begin
      // tx threshold kept at one while the rx side is swept
      bus(1, SPF_OFF_LVL, tx ? {20'h0, 4'(i), 8'h08}
                             : {20'h0, 4'h1, 4'h0, 4'(i)});
      repeat (2) @(posedge clk);
      if (tx) `CHK(tx_empty_flag, (n + i <= 8))
      else `CHK(rx_full_flag, (n >= i))
    end
  endtask : sweep
  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, SPF_OFF_LVL, 32'h0);
    `CHK(q, 32'h0000_0108)
    `CHK(tx_empty_flag, 1'b1)
    bus(1, SPF_OFF_CTRL, 32'h3);
    // shifter stalled: one held, eight queued, tenth dropped
    for (int i = 0; i < 10; i++)
      bus(1, SPF_OFF_TXDATA, 32'hA00 + i);
    `CHK(pen, 1'b1)
    for (int n = 8; n >= 0; n--)
    begin
      sweep(1, n);
      bus(0, SPF_OFF_LVL, 32'h0);
      `CHK(q[15:12], n[3:0])
      @(posedge clk);
      pop <= 1'b1;
      @(posedge clk);
      pop <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK(txw, 16'hA00 + 16'(8 - n))
    end
    for (int n = 1; n <= 8; n++)
    begin
      @(posedge clk);
      rxw <= 16'hC00 + 16'(n);
      push <= 1'b1;
      @(posedge clk);
      push <= 1'b0;
      repeat (3) @(posedge clk);
      sweep(0, n);
      bus(0, SPF_OFF_LVL, 32'h0);
      `CHK(q[7:4], n[3:0])
    end
    bus(0, SPF_OFF_RXDATA, 32'h0);
    `CHK(q[15:0], 16'hC01)
    // queue off: one word held, one pending, third dropped
    bus(1, SPF_OFF_CTRL, 32'h1);
    for (int i = 0; i < 3; i++)
      bus(1, SPF_OFF_TXDATA, 32'hB00 + i);
    bus(0, SPF_OFF_LVL, 32'h0);
    `CHK(q[15:12], 4'h1)
    `CHK(txv, 1'b1)
    bus(1, SPF_OFF_CTRL, 32'h0);
    bus(0, SPF_OFF_LVL, 32'h0);
    `CHK(q[15:4] & 12'hF0F, 12'h0)
    `CHK(txv, 1'b0)
    `CHK(pen, 1'b0)
    report_and_stop();
  end
endmodule : spf_fifo_flags_bench
